// ---- rtl/rsre_regs.svh ----
// Purpose: opcodes and instruction cycle counts for the exec block
// Assumes: one clock, instruction cycles equal clk cycles
// Notes:   definitions only
`ifndef RSRE_REGS_SVH
`define RSRE_REGS_SVH

`define RSRE_OPC_CLR_CARRY   8'hCF
`define RSRE_OPC_RETURN      8'hAF
`define RSRE_OPC_SBC_RR      8'h32
`define RSRE_OPC_SBC_RIR     8'h33
`define RSRE_OPC_SBC_GG      8'h34
`define RSRE_OPC_SBC_GIG     8'h35
`define RSRE_OPC_SBC_IMM     8'h36
`define RSRE_OPC_ROT_L       4'h9
`define RSRE_OPC_ROT_LC      4'h1
`define RSRE_OPC_ROT_R       4'hE
`define RSRE_OPC_ROT_RC      4'hC

`define RSRE_CYC_SHORT       4'h4
`define RSRE_CYC_LONG        4'h6
`define RSRE_CYC_RETURN      4'h8
`define RSRE_SP_STEP         8'h02

`endif

// ---- rtl/rsre_pkg.sv ----
// Purpose: types shared by the exec block and its bench
// Assumes: 8-bit data, 16-bit program counter
// Notes:   constants live in rsre_regs.svh
package rsre_pkg;

  typedef enum logic [2:0] {CLS_NONE, CLS_RCF, CLS_RET, CLS_ROT, CLS_SBC} rsre_cls_t;
  typedef enum logic {ST_IDLE, ST_RUN} rsre_st_t;

  typedef struct packed {
    logic c;
    logic z;
    logic s;
    logic v;
  } rsre_flags_t;

  typedef struct packed {
    logic [7:0] opc;
    logic [7:0] b1;
    logic [7:0] b2;
  } rsre_instr_t;

  typedef struct packed {
    logic       en;
    logic [7:0] addr;
    logic [7:0] data;
  } rsre_wr_t;

  typedef struct packed {
    logic        fl_we;
    rsre_flags_t fl;
    logic        pc_we;
    logic [15:0] pc;
    logic        sp_we;
    logic [7:0]  sp;
  } rsre_upd_t;

endpackage : rsre_pkg

// ---- rtl/rsre_exec.sv ----
// Purpose: executes clear-carry, return, four rotates and subtract-with-borrow
// Assumes: register file read is combinational, writes land one cycle later
// Notes:   the core fetches all instruction bytes before pulsing start
//
// Overview of operation
// - clear-carry zeroes carry only, four cycles
// - return loads pc from stack, sp plus two
// - byte at sp is pc high byte
// - return leaves flags alone, resumes at pc
// - rotate left copies bit7 to bit0, carry
// - rotate left through carry uses old carry
// - rotate right copies bit0 to bit7, carry
// - rotate right through carry uses old carry
// - rotates set zero and sign from result
// - rotates flag overflow when bit7 changes
// - subtract writes dst minus src minus carry
// - subtract never writes the source operand
// - subtract carry means borrow occurred
// - subtract overflow by operand and result signs
// - subtract sign and zero from result
// - subtract encodings 32 to 36, sizes, cycles
`timescale 1ns/1ps
`include "rsre_regs.svh"

module rsre_exec (
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire logic                 start,
  input  wire rsre_pkg::rsre_instr_t instr,
  input  wire logic [3:0]           wreg_base,
  input  wire rsre_pkg::rsre_flags_t flags_in,
  input  wire logic [7:0]           sp_in,
  output logic [7:0]                mem_rd_addr,
  input  wire logic [7:0]           mem_rd_data,
  output rsre_pkg::rsre_wr_t        wr,
  output rsre_pkg::rsre_upd_t       upd,
  output logic                      busy,
  output logic                      done
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic rsre_pkg::rsre_cls_t decode(input logic [7:0] opc);
    rsre_pkg::rsre_cls_t c;
    c = rsre_pkg::CLS_NONE;
    case (opc)
      `RSRE_OPC_CLR_CARRY: c = rsre_pkg::CLS_RCF;
      `RSRE_OPC_RETURN:    c = rsre_pkg::CLS_RET;
      `RSRE_OPC_SBC_RR, `RSRE_OPC_SBC_RIR, `RSRE_OPC_SBC_GG,
      `RSRE_OPC_SBC_GIG, `RSRE_OPC_SBC_IMM:
        c = rsre_pkg::CLS_SBC;
      default:
      begin
        if (opc[3:1] == 3'h0 && (opc[7:4] == `RSRE_OPC_ROT_L ||
            opc[7:4] == `RSRE_OPC_ROT_LC || opc[7:4] == `RSRE_OPC_ROT_R ||
            opc[7:4] == `RSRE_OPC_ROT_RC))
          c = rsre_pkg::CLS_ROT;
      end
    endcase
    return c;
  endfunction : decode

  // cycle count minus one, the index of the last busy cycle
  function automatic logic [3:0] last_step(input logic [7:0] opc);
    logic [3:0] n;
    n = `RSRE_CYC_SHORT;
    if (opc == `RSRE_OPC_RETURN)
      n = `RSRE_CYC_RETURN;
    else if (decode(opc) == rsre_pkg::CLS_SBC && opc != `RSRE_OPC_SBC_RR)
      n = `RSRE_CYC_LONG;
    return n - 4'h1;
  endfunction : last_step

  // returns {carry out, result}
  function automatic logic [8:0] rotate(input logic [3:0] kind,
                                        input logic [7:0] a,
                                        input logic       cin);
    logic [8:0] r;
    case (kind)
      `RSRE_OPC_ROT_LC: r = {a[7], a[6:0], cin};
      `RSRE_OPC_ROT_R:  r = {a[0], a[0], a[7:1]};
      `RSRE_OPC_ROT_RC: r = {a[0], cin, a[7:1]};
      default:          r = {a[7], a[6:0], a[7]};
    endcase
    return r;
  endfunction : rotate

  // returns {borrow, result}; adds the complement of the source
  function automatic logic [8:0] sub_borrow(input logic [7:0] a,
                                            input logic [7:0] b,
                                            input logic       cin);
    logic [8:0] t;
    t = {1'b0, a} + {1'b0, ~b} + {8'h00, ~cin};
    return {~t[8], t[7:0]};
  endfunction : sub_borrow

  ////////////////////////////////////////////////////////////////////////////
  // state
  rsre_pkg::rsre_st_t    st_q, st_d;
  rsre_pkg::rsre_cls_t   cls_q, cls_d;
  rsre_pkg::rsre_instr_t ins_q, ins_d;
  rsre_pkg::rsre_flags_t flb_q, flb_d;
  rsre_pkg::rsre_wr_t    wr_q, wr_d;
  rsre_pkg::rsre_upd_t   upd_q, upd_d;
  logic [3:0]            step_q, step_d;
  logic [3:0]            last_q, last_d;
  logic [3:0]            wb_q, wb_d;
  logic [7:0]            sp_l_q, sp_l_d;
  logic [7:0]            ptr_q, ptr_d;
  logic [7:0]            b_q, b_d;
  logic [7:0]            hi_q, hi_d;
  logic [7:0]            src_v;
  logic                  done_c;
  logic [7:0]            rd_addr_c;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer and datapath
  // one step per cycle; work steps first, the rest pads out the count
  always_comb
  begin
    logic [8:0] res;
    logic [2:0] form;
    logic       ind;
    logic [3:0] work;
    logic [7:0] dsta;
    logic [7:0] srca;
    res    = 9'h000;
    form   = ins_q.opc[2:0];
    ind    = 1'b0;
    work   = 4'h0;
    dsta   = 8'h00;
    srca   = 8'h00;
    st_d   = st_q;
    cls_d  = cls_q;
    ins_d  = ins_q;
    flb_d  = flb_q;
    step_d = step_q;
    last_d = last_q;
    wb_d   = wb_q;
    sp_l_d = sp_l_q;
    ptr_d  = ptr_q;
    b_d    = b_q;
    hi_d   = hi_q;
    src_v  = b_q;
    wr_d   = '0;
    upd_d  = upd_q;
    upd_d.fl_we = 1'b0;
    upd_d.pc_we = 1'b0;
    upd_d.sp_we = 1'b0;
    done_c    = 1'b0;
    rd_addr_c = 8'h00;
    case (st_q)
      rsre_pkg::ST_IDLE:
      begin
        // unknown opcodes are ignored, busy never rises
        if (start && decode(instr.opc) != rsre_pkg::CLS_NONE)
        begin
          st_d   = rsre_pkg::ST_RUN;
          cls_d  = decode(instr.opc);
          ins_d  = instr;
          last_d = last_step(instr.opc);
          flb_d  = flags_in;
          sp_l_d = sp_in;
          wb_d   = wreg_base;
          step_d = 4'h0;
        end
      end
      rsre_pkg::ST_RUN:
      begin
        step_d = step_q + 4'h1;
        if (step_q == last_q)
        begin
          done_c = 1'b1;
          st_d   = rsre_pkg::ST_IDLE;
        end
        case (cls_q)
          rsre_pkg::CLS_RCF:
          begin
            if (step_q == 4'h0)
            begin
              upd_d.fl_we = 1'b1;
              upd_d.fl    = flb_q;
              upd_d.fl.c  = 1'b0;
            end
          end
          rsre_pkg::CLS_RET:
          begin
            // flags untouched; the core fetches from the new pc after done
            if (step_q == 4'h0)
            begin
              rd_addr_c = sp_l_q;
              hi_d      = mem_rd_data;
            end
            else if (step_q == 4'h1)
            begin
              rd_addr_c   = sp_l_q + 8'h01;
              upd_d.pc_we = 1'b1;
              upd_d.pc    = {hi_q, mem_rd_data};
              upd_d.sp_we = 1'b1;
              upd_d.sp    = sp_l_q + `RSRE_SP_STEP;
            end
          end
          rsre_pkg::CLS_ROT:
          begin
            ind  = ins_q.opc[0];
            work = ind ? 4'h1 : 4'h0;
            dsta = ind ? ptr_q : ins_q.b1;
            if (ind && step_q == 4'h0)
            begin
              rd_addr_c = ins_q.b1;
              ptr_d     = mem_rd_data;
            end
            else if (step_q == work)
            begin
              rd_addr_c   = dsta;
              res         = rotate(ins_q.opc[7:4], mem_rd_data, flb_q.c);
              wr_d        = '{en: 1'b1, addr: dsta, data: res[7:0]};
              upd_d.fl_we = 1'b1;
              upd_d.fl.c  = res[8];
              upd_d.fl.z  = (res[7:0] == 8'h00);
              upd_d.fl.s  = res[7];
              upd_d.fl.v  = res[7] ^ mem_rd_data[7];
            end
          end
          rsre_pkg::CLS_SBC:
          begin
            // working forms pack dst and src nibbles into one byte
            ind  = (form == 3'h3) || (form == 3'h5);
            srca = form[2] ? ins_q.b1 : {wb_q, ins_q.b1[3:0]};
            dsta = form[2] ? ins_q.b2 : {wb_q, ins_q.b1[7:4]};
            if (form == 3'h6)
              dsta = ins_q.b1;
            work  = (form == 3'h6) ? 4'h0 : (ind ? 4'h2 : 4'h1);
            src_v = (form == 3'h6) ? ins_q.b2 : b_q;
            if (step_q == 4'h0 && form != 3'h6)
            begin
              rd_addr_c = srca;
              ptr_d     = ind ? mem_rd_data : ptr_q;
              b_d       = ind ? b_q : mem_rd_data;
            end
            else if (step_q == 4'h1 && ind)
            begin
              rd_addr_c = ptr_q;
              b_d       = mem_rd_data;
            end
            else if (step_q == work)
            begin
              // only the destination is written; the source stays intact
              rd_addr_c   = dsta;
              res         = sub_borrow(mem_rd_data, src_v, flb_q.c);
              wr_d        = '{en: 1'b1, addr: dsta, data: res[7:0]};
              upd_d.fl_we = 1'b1;
              upd_d.fl.c  = res[8];
              upd_d.fl.z  = (res[7:0] == 8'h00);
              upd_d.fl.s  = res[7];
              upd_d.fl.v  = (mem_rd_data[7] ^ src_v[7]) &
                            (res[7] == src_v[7]);
            end
          end
          default:
          begin
            st_d = rsre_pkg::ST_IDLE;
          end
        endcase
      end
      default:
      begin
        st_d = rsre_pkg::ST_IDLE;
      end
    endcase
  end

  // register stage; write and update ports are all flop outputs
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_q   <= rsre_pkg::ST_IDLE;
      cls_q  <= rsre_pkg::CLS_NONE;
      ins_q  <= '0;
      flb_q  <= '0;
      wr_q   <= '0;
      upd_q  <= '0;
      step_q <= 4'h0;
      last_q <= 4'h0;
      wb_q   <= 4'h0;
      sp_l_q <= 8'h00;
      ptr_q  <= 8'h00;
      b_q    <= 8'h00;
      hi_q   <= 8'h00;
    end
    else
    begin
      st_q   <= st_d;
      cls_q  <= cls_d;
      ins_q  <= ins_d;
      flb_q  <= flb_d;
      wr_q   <= wr_d;
      upd_q  <= upd_d;
      step_q <= step_d;
      last_q <= last_d;
      wb_q   <= wb_d;
      sp_l_q <= sp_l_d;
      ptr_q  <= ptr_d;
      b_q    <= b_d;
      hi_q   <= hi_d;
    end
  end

  // outputs
  assign mem_rd_addr = rd_addr_c;
  assign wr          = wr_q;
  assign upd         = upd_q;
  assign busy        = (st_q == rsre_pkg::ST_RUN);
  assign done        = done_c;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic acc;
  assign acc = (st_q == rsre_pkg::ST_IDLE) && start &&
               (decode(instr.opc) != rsre_pkg::CLS_NONE);

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_clr_carry_only: assert property (
    acc && instr.opc == `RSRE_OPC_CLR_CARRY |-> ##2
      (upd_q.fl_we && !upd_q.fl.c && upd_q.fl.z == $past(flags_in.z, 2)))
    else $error("clear carry did not clear only carry");
  chk_rot_four_cycles: assert property (
    acc && decode(instr.opc) == rsre_pkg::CLS_ROT |-> ##4 done ##1 !busy)
    else $error("rotate did not take four cycles");
  chk_ret_eight_cycles: assert property (
    acc && instr.opc == `RSRE_OPC_RETURN |-> ##8 done)
    else $error("return did not take eight cycles");
  chk_ret_sp_step: assert property (
    upd_q.pc_we |-> upd_q.sp_we && upd_q.sp == sp_l_q + `RSRE_SP_STEP)
    else $error("return did not add two to sp");
  chk_ret_byte_order: assert property (
    upd_q.pc_we |-> upd_q.pc[15:8] == $past(mem_rd_data, 2) &&
      upd_q.pc[7:0] == $past(mem_rd_data))
    else $error("return loaded pc bytes in wrong order");
  chk_ret_no_flags: assert property (
    busy && cls_q == rsre_pkg::CLS_RET |=> !upd_q.fl_we)
    else $error("return touched the flags");
  chk_rot_zero_sign: assert property (
    wr_q.en && cls_q == rsre_pkg::CLS_ROT |->
      upd_q.fl.z == (wr_q.data == 8'h00) && upd_q.fl.s == wr_q.data[7])
    else $error("rotate zero or sign flag wrong");
  chk_rot_overflow: assert property (
    wr_q.en && cls_q == rsre_pkg::CLS_ROT |->
      upd_q.fl.v == (wr_q.data[7] ^ $past(mem_rd_data[7])))
    else $error("rotate overflow flag wrong");
  chk_sbc_difference: assert property (
    wr_q.en && cls_q == rsre_pkg::CLS_SBC |-> {upd_q.fl.c, wr_q.data} ==
      $past({1'b0, mem_rd_data} - {1'b0, src_v} - {8'h00, flb_q.c}))
    else $error("subtract result or borrow wrong");
  chk_sbc_dst_only: assert property (
    wr_q.en && cls_q == rsre_pkg::CLS_SBC |-> wr_q.addr == $past(mem_rd_addr))
    else $error("subtract wrote other than destination");
  cov_clr_carry: cover property (acc && instr.opc == `RSRE_OPC_CLR_CARRY);
  cov_ret_done:  cover property (busy && cls_q == rsre_pkg::CLS_RET && done);
  cov_sbc_imm:   cover property (wr_q.en && ins_q.opc == `RSRE_OPC_SBC_IMM);
  cov_rot_ind:   cover property (wr_q.en && cls_q == rsre_pkg::CLS_ROT && ins_q.opc[0]);

endmodule : rsre_exec

// ---- test/rsre_exec_tb.sv ----
// Purpose: self-checking bench for the rotate, subtract, return exec block
// Assumes: inputs driven at falling edge, register file modelled as array
// Notes:   expected values worked out here, never taken from the design
`timescale 1ns/1ps
`include "rsre_regs.svh"

module rsre_exec_tb;

  logic                  clk;
  logic                  sys_rst;
  logic                  start;
  rsre_pkg::rsre_instr_t instr;
  logic [3:0]            wreg_base;
  rsre_pkg::rsre_flags_t flags_in;
  logic [7:0]            sp_in;
  logic [7:0]            mem_rd_addr;
  logic [7:0]            mem_rd_data;
  rsre_pkg::rsre_wr_t    wr;
  rsre_pkg::rsre_upd_t   upd;
  logic                  busy;
  logic                  done;
  logic [7:0]            mem [256];
  int                    fail_count;
  int                    checked;
  int                    wr_cnt;
  int                    fl_cnt;
  int                    pc_cnt;
  int                    sp_cnt;

  rsre_exec dut (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .start       (start),
    .instr       (instr),
    .wreg_base   (wreg_base),
    .flags_in    (flags_in),
    .sp_in       (sp_in),
    .mem_rd_addr (mem_rd_addr),
    .mem_rd_data (mem_rd_data),
    .wr          (wr),
    .upd         (upd),
    .busy        (busy),
    .done        (done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // clock and register file model; read is combinational as the core expects
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  assign mem_rd_data = mem[mem_rd_addr];

  // writes land at the edge, pulses counted so stray writes are seen
  always @(posedge clk)
  begin
    if (wr.en === 1'b1)
    begin
      mem[wr.addr] <= wr.data;
      wr_cnt++;
    end
    if (upd.fl_we === 1'b1) fl_cnt++;
    if (upd.pc_we === 1'b1) pc_cnt++;
    if (upd.sp_we === 1'b1) sp_cnt++;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize

  // filler pattern differs per address so a wrong read address shows up
  task automatic init_mem();
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
    mem[8'hC1] = 8'h10;
    mem[8'hC2] = 8'h03;
    mem[8'h01] = 8'h20;
    mem[8'h02] = 8'h03;
    mem[8'h03] = 8'h0A;
  endtask : init_mem

  // one start pulse, then count cycles to done under a bound
  task automatic run(input logic [23:0] ins, input logic [3:0] f, input int n);
    int k;
    wr_cnt = 0;
    fl_cnt = 0;
    pc_cnt = 0;
    sp_cnt = 0;
    @(negedge clk);
    start = 1'b1;
    instr = ins;
    flags_in = f;
    @(negedge clk);
    start = 1'b0;
    k = 1;
    while (done !== 1'b1 && k < 20)
    begin
      @(negedge clk);
      k++;
    end
    chk("cycles", 16'(n), 16'(k));
    @(negedge clk);
  endtask : run

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_clear();
    run({`RSRE_OPC_CLR_CARRY, 16'h0}, 4'b1101, 4);
    chk("clr_flags", 16'h5, 16'(upd.fl));
    run({`RSRE_OPC_CLR_CARRY, 16'h0}, 4'b0010, 4);
    chk("clr_flags", 16'h2, 16'(upd.fl));
    chk("clr_writes", 16'h0, 16'(wr_cnt));
    chk("clr_fl_we", 16'h1, 16'(fl_cnt));
    chk("clr_pc_sp_we", 16'h0, 16'(pc_cnt + sp_cnt));
  endtask : t_clear

  task automatic t_return();
    sp_in = 8'hBC;
    mem[8'hBC] = 8'h10;
    mem[8'hBD] = 8'h1A;
    run({`RSRE_OPC_RETURN, 16'h0}, 4'b1010, 8);
    chk("ret_pc", 16'h101A, upd.pc);
    chk("ret_sp", 16'h00BE, 16'(upd.sp));
    chk("ret_pc_we", 16'h1, 16'(pc_cnt));
    chk("ret_sp_we", 16'h1, 16'(sp_cnt));
    chk("ret_fl_we", 16'h0, 16'(fl_cnt));
  endtask : t_return

  // every rotate in direct and indirect form; pointer at 21 names 20
  task automatic t_rotate(input logic [7:0] v, input logic cin);
    logic [3:0] nib [4];
    logic [7:0] r;
    logic       c;
    nib = '{`RSRE_OPC_ROT_L, `RSRE_OPC_ROT_LC, `RSRE_OPC_ROT_R, `RSRE_OPC_ROT_RC};
    for (int i = 0; i < 4; i++)
    begin
      for (int d = 0; d < 2; d++)
      begin
        init_mem();
        mem[8'h20] = v;
        mem[8'h21] = 8'h20;
        case (i)
          0: r = {v[6:0], v[7]};
          1: r = {v[6:0], cin};
          2: r = {v[0], v[7:1]};
          default: r = {cin, v[7:1]};
        endcase
        c = (i < 2) ? v[7] : v[0];
        run({nib[i], 3'b000, d[0], (d == 1) ? 8'h21 : 8'h20, 8'h00}, {cin, 3'b000}, 4);
        chk("rot_result", 16'(r), 16'(mem[8'h20]));
        chk("rot_flags", 16'({c, r == 8'h00, r[7], r[7] ^ v[7]}), 16'(upd.fl));
        chk("rot_writes", 16'h1, 16'(wr_cnt));
      end
    end
  endtask : t_rotate

  // all five subtract forms plus an immediate that can hit zero
  task automatic t_sbc(input logic cin);
    logic [7:0] op [6];
    logic [7:0] b1 [6];
    logic [7:0] b2 [6];
    logic [7:0] da [6];
    logic [7:0] sa [6];
    logic [7:0] d;
    logic [7:0] s;
    logic [8:0] full;
    logic       ov;
    logic [3:0] ef;
    op = '{8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h36};
    b1 = '{8'h12, 8'h12, 8'h02, 8'h02, 8'h01, 8'h01};
    b2 = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h8A, 8'h20};
    da = '{8'hC1, 8'hC1, 8'h01, 8'h01, 8'h01, 8'h01};
    sa = '{8'hC2, 8'h03, 8'h02, 8'h03, 8'h00, 8'h00};
    wreg_base = 4'hC;
    for (int i = 0; i < 6; i++)
    begin
      init_mem();
      d = mem[da[i]];
      s = (i >= 4) ? b2[i] : mem[sa[i]];
      full = {1'b0, d} - {1'b0, s} - 9'(cin);
      ov = (d[7] != s[7]) && (full[7] == s[7]);
      ef = {full[8], full[7:0] == 8'h00, full[7], ov};
      run({op[i], b1[i], b2[i]}, {cin, 3'b000}, (i == 0) ? 4 : 6);
      chk("sbc_result", 16'(full[7:0]), 16'(mem[da[i]]));
      chk("sbc_flags", 16'(ef), 16'(upd.fl));
      chk("sbc_writes", 16'h1, 16'(wr_cnt));
    end
  endtask : t_sbc

  // unknown opcode, then start held high through a whole clear-carry
  task automatic t_refuse();
    int k;
    init_mem();
    wr_cnt = 0;
    fl_cnt = 0;
    @(negedge clk);
    start = 1'b1;
    instr = {8'hFF, 8'h01, 8'h00};
    @(negedge clk);
    start = 1'b0;
    chk("unknown_busy", 16'h0, 16'(busy));
    repeat (3) @(negedge clk);
    chk("unknown_pulses", 16'h0, 16'(wr_cnt + fl_cnt));
    start = 1'b1;
    instr = {`RSRE_OPC_CLR_CARRY, 16'h0};
    flags_in = 4'hF;
    @(negedge clk);
    instr = {8'h36, 8'h01, 8'h8A};
    k = 1;
    while (done !== 1'b1 && k < 20)
    begin
      @(negedge clk);
      k++;
    end
    chk("held_cycles", 16'h4, 16'(k));
    @(negedge clk);
    start = 1'b0;
    chk("held_busy", 16'h0, 16'(busy));
    chk("held_writes", 16'h0, 16'(wr_cnt));
  endtask : t_refuse

  ////////////////////////////////////////////////////////////////////////////
  // main sequence; watchdog covers a design that never finishes
  initial
  begin
    fail_count = 0;
    checked = 0;
    sys_rst = 1'b1;
    start = 1'b0;
    instr = '0;
    wreg_base = 4'h0;
    flags_in = '0;
    sp_in = 8'h00;
    init_mem();
    repeat (10) @(negedge clk);
    sys_rst = 1'b0;
    chk("rst_busy", 16'h0, 16'(busy));
    t_clear();
    t_return();
    t_rotate(8'hAA, 1'b0);
    t_rotate(8'h80, 1'b0);
    t_rotate(8'h01, 1'b0);
    t_rotate(8'h55, 1'b1);
    t_sbc(1'b1);
    t_sbc(1'b0);
    t_refuse();
    summarize();
  end

  initial
  begin
    #1000000;
    fail_count++;
    $display("[ERR] watchdog expected finish seen timeout");
    summarize();
  end

endmodule : rsre_exec_tb
